// ==== tb_torque_status_mode_select.sv ====
// Purpose: self-checking bench for tsms_top
// Assumes: limits fwd 2000 rev 1500, threshold 100 percent, hysteresis 10 percent
// Notes: expectations come from integer models, not from the design
`timescale 1ns/1ps
`default_nettype none
`include "tsms_cfg.svh"
module tb_torque_status_mode_select;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic servo_on_i = 1'b0;
    logic drive_run_i = 1'b0;
    logic signed [15:0] torque_req_i = 16'sh0;
    logic signed [15:0] torque_act_i = 16'sh0;
    logic signed [15:0] speed_act_i = 16'sh0;
    logic sel = 1'b0;
    logic [3:0] di_i;
    logic [31:0] rdata_o;
    logic signed [15:0] torque_cmd_o;
    logic signed [15:0] speed_ref_o;
    logic speed_clamp_o;
    logic irq_o;
    logic [2:0] active_mode_o;
    logic [3:0] do_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 32'h19fd;
    logic [7:0] ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24, 8'h28,
        8'h2c, 8'h30, 8'h34, 8'h3c};
    int rv [13] = '{1, 3000, 3000, 3000, 3000, 100, 10, 0, 0, 15, 0, 15, 0};
    int rq [6] = '{2000, 2001, -1500, -1501, 0, 3500};
    int ac [6] = '{1099, 1100, 900, 899, -1100, -899};
    int sp [3] = '{3000, -3000, 2999};

    tsms_top u_tsms_top (.clock_i(clock_i), .reset_i(reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .servo_on_i(servo_on_i), .drive_run_i(drive_run_i), .torque_req_i(torque_req_i),
        .torque_act_i(torque_act_i), .torque_cmd_o(torque_cmd_o), .speed_act_i(speed_act_i),
        .speed_clamp_o(speed_clamp_o), .speed_ref_o(speed_ref_o),
        .active_mode_o(active_mode_o), .di_i(di_i), .do_o(do_o), .irq_o(irq_o));
    tsms_host u_tsms_host (.clock_i(clock_i), .sel_i(sel), .lvl_i(1'b0),
        .speed_i(speed_act_i), .di_o(di_i));

    // 125 MHz clock
    initial forever #4 clock_i = ~clock_i;

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    // bus cycles: one-cycle strobe, read data the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk($sformatf("register %h", a), exp, rdata_o);
    endtask
    // selector passes the host flop, two sync flops and the mode register, so 5 edges is ample
    task automatic drive(input logic on, input logic run, input logic s, input int exp);
        @(posedge clock_i);
        servo_on_i <= on;
        drive_run_i <= run;
        sel <= s;
        repeat (5) @(posedge clock_i);
        #1;
        if (exp > 0) chk("active_mode_o", exp, active_mode_o);
    endtask
    function automatic int mode_of(int m, bit s);
        case (m)
            4: return s ? 2 : 1;
            5: return s ? 4 : 1;
            6: return s ? 4 : 2;
            default: return 1 << (m - 1);
        endcase
    endfunction

    // hang guard
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        summarize();
    end

    // main sequence
    initial begin
        int t, a, v, lim, arr, cl;
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        // oversized settings saturate
        wr(`TSMS_A_FWD_SCLP, 32'h1770);
        wr(`TSMS_A_ARR_THR, 32'h190);
        wr(`TSMS_A_ARR_HYS, 32'h19);
        rd(`TSMS_A_FWD_SCLP, 32'h1388);
        rd(`TSMS_A_ARR_THR, 32'h12c);
        rd(`TSMS_A_ARR_HYS, 32'h14);
        wr(`TSMS_A_FWD_SCLP, 32'hbb8);
        wr(`TSMS_A_ARR_THR, 32'h64);
        wr(`TSMS_A_ARR_HYS, 32'h0a);
        // terminal 0 limited, 1 arrival, 2 limited active low, 3 unassigned
        wr(`TSMS_A_FWD_TLIM, 32'h7d0);
        wr(`TSMS_A_REV_TLIM, 32'h5dc);
        wr(`TSMS_A_DO_FUNC, 32'h008b8a8b);
        wr(`TSMS_A_DO_LVL, 32'hb);
        arr = 0;
        for (int i = 0; i < 70; i++) begin
            t = (i < 6) ? rq[i] : $random(seed) % 4000;
            a = (i < 6) ? ac[i] : $random(seed) % 1300;
            @(posedge clock_i);
            torque_req_i <= 16'(t);
            torque_act_i <= 16'(a);
            repeat (2) @(posedge clock_i);
            #1;
            lim = (t > 2000 || t < -1500);
            v = (t > 2000) ? 2000 : (t < -1500) ? -1500 : t;
            if (a >= 1100 || a <= -1100) arr = 1;
            else if (a < 900 && a > -900) arr = 0;
            chk("torque_cmd_o", v, 32'(torque_cmd_o));
            chk("do_o", (lim ? 1 : 4) | (arr ? 2 : 0), {28'h0, do_o});
        end
        // sticky events, masked, then enabled, cleared by ones
        @(posedge clock_i);
        torque_req_i <= 16'sh0;
        torque_act_i <= 16'sh0;
        #1 chk("irq_o", 0, {31'h0, irq_o});
        rd(`TSMS_A_IRQ_STAT, 32'h3);
        wr(`TSMS_A_IRQ_MASK, 32'h2);
        #1 chk("irq_o", 1, {31'h0, irq_o});
        wr(`TSMS_A_IRQ_STAT, 32'h3);
        #1 chk("irq_o", 0, {31'h0, irq_o});
        // selector on terminal 0, active low; walk every control mode setting
        wr(`TSMS_A_DI_FUNC, 32'h11);
        wr(`TSMS_A_DI_LVL, 32'he);
        for (int m = 1; m <= 6; m++) begin
            drive(0, 0, 0, 0);
            wr(`TSMS_A_MODE, m);
            drive(0, 0, 1, mode_of(m, 0));
            drive(1, 1, 1, mode_of(m, 1));
            drive(1, 0, 0, mode_of(m, 1));
            drive(1, 1, 0, mode_of(m, 0));
            wr(`TSMS_A_MODE, 32'h2);
            rd(`TSMS_A_MODE, m);
            for (int k = 0; k < 3; k++) begin
                @(posedge clock_i);
                speed_act_i <= 16'(sp[k]);
                repeat (2) @(posedge clock_i);
                #1;
                cl = (mode_of(m, 0) == 4 && k < 2);
                chk("speed_clamp_o", cl, {31'h0, speed_clamp_o});
                chk("speed_ref_o", cl ? sp[k] : 0, 32'(speed_ref_o));
            end
            @(posedge clock_i);
            speed_act_i <= 16'sh0;
        end
        drive(0, 0, 0, 0);
        wr(`TSMS_A_MODE, 32'h7);
        rd(`TSMS_A_MODE, 32'h6);
        summarize();
    end
endmodule
`default_nettype wire

// ==== tsms_cfg.svh ====
// Purpose: constants for the torque status and mode select block
// Assumes: one 125 MHz clock, register port with 8-bit byte addresses
// Notes: definitions only
`ifndef TSMS_CFG_SVH
`define TSMS_CFG_SVH

// register addresses
`define TSMS_A_MODE 8'h00
`define TSMS_A_FWD_TLIM 8'h04
`define TSMS_A_REV_TLIM 8'h08
`define TSMS_A_FWD_SCLP 8'h0c
`define TSMS_A_REV_SCLP 8'h10
`define TSMS_A_ARR_THR 8'h14
`define TSMS_A_ARR_HYS 8'h18
`define TSMS_A_STATUS 8'h1c
`define TSMS_A_IRQ_STAT 8'h20
`define TSMS_A_IRQ_MASK 8'h24
`define TSMS_A_DO_FUNC 8'h28
`define TSMS_A_DO_LVL 8'h2c
`define TSMS_A_DI_FUNC 8'h30
`define TSMS_A_DI_LVL 8'h34

// control mode setting codes
`define TSMS_CM_POS 3'h1
`define TSMS_CM_SPD 3'h2
`define TSMS_CM_TRQ 3'h3
`define TSMS_CM_PS 3'h4
`define TSMS_CM_PT 3'h5
`define TSMS_CM_ST 3'h6

// terminal function codes
`define TSMS_FN_TARR 8'h8a
`define TSMS_FN_TLIM 8'h8b
`define TSMS_FN_MIXSEL 8'h11

// reset values and ranges, torque and speed limits in 0.1 percent
`define TSMS_TLIM_RST 12'hbb8
`define TSMS_TLIM_MAX 12'hbb8
`define TSMS_SCLP_RST 13'hbb8
`define TSMS_SCLP_MAX 13'h1388
`define TSMS_THR_RST 9'h064
`define TSMS_THR_MAX 9'h12c
`define TSMS_HYS_RST 5'h0a
`define TSMS_HYS_MAX 5'h14

// percent to 0.1 percent
`define TSMS_PCT_SCALE 18'sh0000a

// interrupt status bit positions
`define TSMS_EV_ARR 0
`define TSMS_EV_TLIM 1
`define TSMS_EV_SCLP 2
`define TSMS_EV_MODE 3

`endif

// ==== tsms_chk_properties.sv ====
// Purpose: port-level checks for tsms_top
// Assumes: one clock, reset_i asynchronous and active high
// Notes: limit registers are unseen, so bounds use the legal maxima
`timescale 1ns/1ps
`default_nettype none
`include "tsms_cfg.svh"
module tsms_chk (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // drive state and paths
    input wire logic servo_on_i,
    input wire logic drive_run_i,
    input wire logic signed [15:0] torque_req_i,
    input wire logic signed [15:0] torque_cmd_o,
    input wire logic signed [15:0] speed_act_i,
    input wire logic speed_clamp_o,
    input wire logic signed [15:0] speed_ref_o,
    input wire logic [2:0] active_mode_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // register port and torque path
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("stray read data");
    a_cmd_bound: assert property (torque_cmd_o <= 16'sd3000 && torque_cmd_o >= -16'sd3000)
        else $error("command over limit");
    a_cmd_follow: assert property ($past(torque_req_i) >= 0
        |-> torque_cmd_o >= 0 && torque_cmd_o <= $past(torque_req_i))
        else $error("command above request");
    // speed clamp
    a_ref_zero: assert property (!speed_clamp_o |-> speed_ref_o == 16'sh0)
        else $error("reference without clamp");
    a_clamp_trq: assert property (speed_clamp_o |-> active_mode_o == tsms_pkg::TSMS_TRQ
        || $past(active_mode_o) == tsms_pkg::TSMS_TRQ)
        else $error("clamp outside torque mode");
    a_clamp_hold: assert property (speed_clamp_o && speed_ref_o != 16'sh0 |-> (speed_ref_o > 0)
        ? $past(speed_act_i) >= speed_ref_o : $past(speed_act_i) <= speed_ref_o)
        else $error("clamp below clamp value");
    // mode selection and register ranges
    a_mode_onehot: assert property ($onehot(active_mode_o))
        else $error("active mode not one-hot");
    a_mode_hold: assert property ($changed(active_mode_o)
        |-> !($past(servo_on_i) && !$past(drive_run_i)))
        else $error("mode changed while idle");
    a_mode_range: assert property (rd_i && addr_i == `TSMS_A_MODE
        |=> rdata_o[31:3] == 29'h0 && rdata_o[2:0] inside {[3'h1:3'h6]})
        else $error("mode setting out of range");
    a_sclp_range: assert property (rd_i && (addr_i == `TSMS_A_FWD_SCLP
        || addr_i == `TSMS_A_REV_SCLP) |=> rdata_o <= 32'h1388)
        else $error("clamp setting too high");
    a_thr_range: assert property (rd_i && addr_i == `TSMS_A_ARR_THR |=> rdata_o <= 32'h12c)
        else $error("threshold too high");
    // main scenarios
    c_clamp: cover property (speed_clamp_o && speed_ref_o < 0);
    c_mixed: cover property ($changed(active_mode_o) && servo_on_i && drive_run_i);
    c_limit: cover property (torque_cmd_o == 16'sd2000 || torque_cmd_o == -16'sd1500);
endmodule
bind tsms_top tsms_chk u_tsms_chk (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .servo_on_i(servo_on_i), .drive_run_i(drive_run_i),
    .torque_req_i(torque_req_i), .torque_cmd_o(torque_cmd_o), .speed_act_i(speed_act_i),
    .speed_clamp_o(speed_clamp_o), .speed_ref_o(speed_ref_o), .active_mode_o(active_mode_o));
`default_nettype wire

// ==== tsms_do_map.sv ====
// Purpose: maps status flags onto configurable output terminals
// Assumes: one 8-bit function code and one active-level bit per terminal
// Notes: unassigned terminals show their inactive level
`timescale 1ns/1ps
`default_nettype none
`include "tsms_cfg.svh"
module tsms_do_map #(
    parameter int N_DO = 4
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // flags
    input wire logic limited_i,
    input wire logic arrived_i,
    // terminal configuration
    input wire logic [8*N_DO-1:0] func_i,
    input wire logic [N_DO-1:0] lvl_i,
    // terminals
    output logic [N_DO-1:0] do_o
);
    logic [N_DO-1:0] valid;
    logic [N_DO-1:0] next_do;

    // a terminal is valid when its function flag is set; level 1 means active high
    for (genvar g = 0; g < N_DO; g++) begin : g_term
        assign valid[g] = ((func_i[8*g +: 8] == `TSMS_FN_TLIM) && limited_i) ||  // RULE_01
                          ((func_i[8*g +: 8] == `TSMS_FN_TARR) && arrived_i);    // RULE_07
        assign next_do[g] = lvl_i[g] ? valid[g] : ~valid[g];                    // RULE_14
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            do_o <= '0;
        end else begin
            do_o <= next_do;
        end
    end
endmodule
`default_nettype wire

// ==== tsms_host.sv ====
// Purpose: host side of the input terminals
// Assumes: terminal 0 carries the mixed-mode selector
// Notes: spare terminals toggle freely
`timescale 1ns/1ps
`default_nettype none
module tsms_host (
    // clock
    input wire logic clock_i,
    // selector request and terminal level
    input wire logic sel_i,
    input wire logic lvl_i,
    input wire logic signed [15:0] speed_i,
    // terminals toward the drive
    output logic [3:0] di_o
);
    logic [2:0] spare = 3'h0;
    initial di_o = 4'h1;
    // selector moves only near standstill
    always @(posedge clock_i) begin
        spare <= spare + 3'h1;
        di_o[3:1] <= spare;
        if (speed_i < 16'sd100 && speed_i > -16'sd100) begin
            di_o[0] <= sel_i ? lvl_i : ~lvl_i;
        end
    end
endmodule
`default_nettype wire

// ==== tsms_hyst.sv ====
// Purpose: torque arrival comparator with hysteresis
// Assumes: torque in 0.1 percent, threshold and hysteresis in whole percent
// Notes: if hysteresis exceeds threshold the lower bound is negative and the flag never clears
`timescale 1ns/1ps
`default_nettype none
`include "tsms_cfg.svh"
module tsms_hyst (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // settings and measurement
    input wire logic signed [15:0] torque_i,
    input wire logic [8:0] thr_i,
    input wire logic [4:0] hys_i,
    // flag
    output logic arrived_o
);
    logic signed [17:0] mag;
    logic signed [17:0] upper;
    logic signed [17:0] lower;

    // magnitude and the two bounds, all in 0.1 percent
    assign mag = torque_i[15] ? -{{2{torque_i[15]}}, torque_i} : {{2{torque_i[15]}}, torque_i};
    assign upper = ($signed({9'h000, thr_i}) + $signed({13'h0000, hys_i})) * `TSMS_PCT_SCALE;
    assign lower = ($signed({9'h000, thr_i}) - $signed({13'h0000, hys_i})) * `TSMS_PCT_SCALE;

    // set at or above upper, clear below lower, hold between
    wire next_arrived = (mag >= upper) ? 1'b1 :   // RULE_05
                          (mag < lower) ? 1'b0 :    // RULE_06
                          arrived_o;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            arrived_o <= 1'b0;
        end else begin
            arrived_o <= next_arrived;
        end
    end
endmodule
`default_nettype wire

// ==== tsms_pkg.sv ====
// Purpose: types for the torque status and mode select block
// Assumes: nothing beyond the cfg header
// Notes: active control mode is kept one-hot
package tsms_pkg;
    typedef enum logic [2:0] {
        TSMS_POS = 3'b001,
        TSMS_SPD = 3'b010,
        TSMS_TRQ = 3'b100
    } tsms_mode_e;
endpackage

// ==== tsms_top.sv ====
// Purpose: torque status flags, torque-mode speed clamp, mixed-mode selection
// Assumes: torque and speed in 0.1 percent from logic on clock_i; di_i from pins
// Notes: registers over a plain port, read data one cycle after the strobe
//
// Summary of operation
// (RULE_01) flag torque limited on function 139 terminals
// (RULE_02) torque mode: hold speed at clamp
// (RULE_03) speed clamps 0..5000, reset 3000
// (RULE_04) speed clamps only act in torque mode
// (RULE_05) arrival sets at threshold plus hysteresis
// (RULE_06) arrival clears below threshold minus hysteresis
// (RULE_07) arrival flag on function 138 terminals
// (RULE_08) threshold 0..300 default 100, hysteresis 0..20 default 10
// (RULE_09) mixed switching only when enabled and running
// (RULE_10) control mode 1..6, default 1
// (RULE_11) host assigns function 17 input in mixed modes
// (RULE_12) selector picks mode per mixed setting
// (RULE_13) host should switch at low speed
// (RULE_14) every terminal has its own active level
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "tsms_cfg.svh"
module tsms_top #(
    parameter int N_DO = 4,
    parameter int N_DI = 4
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // drive state
    input wire logic servo_on_i,
    input wire logic drive_run_i,
    // torque path
    input wire logic signed [15:0] torque_req_i,
    input wire logic signed [15:0] torque_act_i,
    output logic signed [15:0] torque_cmd_o,
    // speed path
    input wire logic signed [15:0] speed_act_i,
    output logic speed_clamp_o,
    output logic signed [15:0] speed_ref_o,
    // mode
    output logic [2:0] active_mode_o,
    // terminals
    input wire logic [N_DI-1:0] di_i,
    output logic [N_DO-1:0] do_o,
    // interrupt
    output logic irq_o
);
    // clamps a written value to its legal maximum
    function automatic logic [12:0] sat13(input logic [31:0] v, input logic [12:0] max);
        sat13 = (v > {19'h00000, max}) ? max : v[12:0];
    endfunction

    // configuration registers
    logic [2:0] mode_setting;
    logic [11:0] fwd_tlim;
    logic [11:0] rev_tlim;
    logic [12:0] fwd_speed_clamp_torque_mode;
    logic [12:0] rev_speed_clamp_torque_mode;
    logic [8:0] arrival_threshold;
    logic [4:0] arrival_hysteresis;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [8*N_DO-1:0] do_func;
    logic [N_DO-1:0] do_lvl;
    logic [8*N_DI-1:0] di_func;
    logic [N_DI-1:0] di_lvl;

    // register write decode
    wire wr_mode = wr_i && (addr_i == `TSMS_A_MODE);
    wire wr_ftl = wr_i && (addr_i == `TSMS_A_FWD_TLIM);
    wire wr_rtl = wr_i && (addr_i == `TSMS_A_REV_TLIM);
    wire wr_fsc = wr_i && (addr_i == `TSMS_A_FWD_SCLP);
    wire wr_rsc = wr_i && (addr_i == `TSMS_A_REV_SCLP);
    wire wr_thr = wr_i && (addr_i == `TSMS_A_ARR_THR);
    wire wr_hys = wr_i && (addr_i == `TSMS_A_ARR_HYS);
    wire wr_istat = wr_i && (addr_i == `TSMS_A_IRQ_STAT);
    wire wr_imask = wr_i && (addr_i == `TSMS_A_IRQ_MASK);
    wire wr_dof = wr_i && (addr_i == `TSMS_A_DO_FUNC);
    wire wr_dol = wr_i && (addr_i == `TSMS_A_DO_LVL);
    wire wr_dif = wr_i && (addr_i == `TSMS_A_DI_FUNC);
    wire wr_dil = wr_i && (addr_i == `TSMS_A_DI_LVL);
    // mode is a shutdown setting: codes outside 1..6 or writes while enabled are dropped
    wire mode_legal = (wdata_i[31:3] == 29'h0) && (wdata_i[2:0] >= `TSMS_CM_POS) &&
                        (wdata_i[2:0] <= `TSMS_CM_ST) && !servo_on_i;

    // configuration storage; range limits other than the mode code saturate rather than reject
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode_setting <= `TSMS_CM_POS;
            fwd_tlim <= `TSMS_TLIM_RST;
            rev_tlim <= `TSMS_TLIM_RST;
            fwd_speed_clamp_torque_mode <= `TSMS_SCLP_RST;
            rev_speed_clamp_torque_mode <= `TSMS_SCLP_RST;
            arrival_threshold <= `TSMS_THR_RST;
            arrival_hysteresis <= `TSMS_HYS_RST;
            irq_mask <= 4'h0;
            do_func <= '0;
            do_lvl <= '1;
            di_func <= '0;
            di_lvl <= '1;
        end else begin
            if (wr_mode && mode_legal) mode_setting <= wdata_i[2:0]; // RULE_10
            if (wr_ftl) fwd_tlim <= 12'(sat13(wdata_i, {1'b0, `TSMS_TLIM_MAX}));
            if (wr_rtl) rev_tlim <= 12'(sat13(wdata_i, {1'b0, `TSMS_TLIM_MAX}));
            if (wr_fsc) fwd_speed_clamp_torque_mode <= sat13(wdata_i, `TSMS_SCLP_MAX); // RULE_03
            if (wr_rsc) rev_speed_clamp_torque_mode <= sat13(wdata_i, `TSMS_SCLP_MAX); // RULE_03
            if (wr_thr) arrival_threshold <= 9'(sat13(wdata_i, {4'h0, `TSMS_THR_MAX})); // RULE_08
            if (wr_hys) arrival_hysteresis <= 5'(sat13(wdata_i, {8'h0, `TSMS_HYS_MAX})); // RULE_08
            if (wr_imask) irq_mask <= wdata_i[3:0];
            if (wr_dof) do_func <= wdata_i[8*N_DO-1:0];
            if (wr_dol) do_lvl <= wdata_i[N_DO-1:0];
            if (wr_dif) di_func <= wdata_i[8*N_DI-1:0];
            if (wr_dil) di_lvl <= wdata_i[N_DI-1:0];
        end
    end

    // input terminals come from pins, so two flops before any use
    logic [N_DI-1:0] di_meta;
    logic [N_DI-1:0] di_sync;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            {di_sync, di_meta} <= '0;
        end else begin
            {di_sync, di_meta} <= {di_meta, di_i};
        end
    end

    // selector is valid when any function-17 terminal sits at its active level
    logic [N_DI-1:0] sel_hit;
    for (genvar g = 0; g < N_DI; g++) begin : g_di
        assign sel_hit[g] = (di_func[8*g +: 8] == `TSMS_FN_MIXSEL) &&
                            (di_sync[g] == di_lvl[g]); // RULE_14
    end
    wire mixed_mode_selector = |sel_hit;

    // mode wanted by the setting and the selector
    tsms_pkg::tsms_mode_e mode;
    tsms_pkg::tsms_mode_e want_mode;
    tsms_pkg::tsms_mode_e base_mode;
    tsms_pkg::tsms_mode_e next_mode;

    always_comb begin
        case (mode_setting)
            `TSMS_CM_SPD: begin
                base_mode = tsms_pkg::TSMS_SPD;
                want_mode = tsms_pkg::TSMS_SPD;
            end
            `TSMS_CM_TRQ: begin
                base_mode = tsms_pkg::TSMS_TRQ;
                want_mode = tsms_pkg::TSMS_TRQ;
            end
            `TSMS_CM_PS: begin
                base_mode = tsms_pkg::TSMS_POS;
                want_mode = mixed_mode_selector ? tsms_pkg::TSMS_SPD : tsms_pkg::TSMS_POS; // RULE_12
            end
            `TSMS_CM_PT: begin
                base_mode = tsms_pkg::TSMS_POS;
                want_mode = mixed_mode_selector ? tsms_pkg::TSMS_TRQ : tsms_pkg::TSMS_POS; // RULE_12
            end
            `TSMS_CM_ST: begin
                base_mode = tsms_pkg::TSMS_SPD;
                want_mode = mixed_mode_selector ? tsms_pkg::TSMS_TRQ : tsms_pkg::TSMS_SPD; // RULE_12
            end
            default: begin
                base_mode = tsms_pkg::TSMS_POS;
                want_mode = tsms_pkg::TSMS_POS;
            end
        endcase
    end
    wire is_mixed = (mode_setting >= `TSMS_CM_PS);

    // in mixed operation the selector is obeyed only while enabled and running;
    // disabled the drive rests in the setting's base mode, enabled but idle it holds
    always_comb begin
        case (mode)
            tsms_pkg::TSMS_POS, tsms_pkg::TSMS_SPD, tsms_pkg::TSMS_TRQ: begin
                if (!is_mixed) begin
                    next_mode = want_mode;
                end else if (!servo_on_i) begin
                    next_mode = base_mode;
                end else if (drive_run_i) begin
                    next_mode = want_mode; // RULE_09
                end else begin
                    next_mode = mode;
                end
            end
            default: begin
                next_mode = base_mode;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode <= tsms_pkg::TSMS_POS;
        end else begin
            mode <= next_mode;
        end
    end
    assign active_mode_o = mode;

    // torque command clamped at the limits
    logic torque_limited;
    wire signed [16:0] req_ext = {torque_req_i[15], torque_req_i};
    wire signed [16:0] fwd_lim_s = $signed({5'h00, fwd_tlim});
    wire signed [16:0] rev_lim_s = -$signed({5'h00, rev_tlim});
    wire tlim_hi = req_ext > fwd_lim_s;
    wire tlim_lo = req_ext < rev_lim_s;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            torque_cmd_o <= 16'sh0000;
            torque_limited <= 1'b0;
        end else begin
            torque_cmd_o <= tlim_hi ? fwd_lim_s[15:0] : tlim_lo ? rev_lim_s[15:0] : torque_req_i;
            torque_limited <= tlim_hi || tlim_lo; // RULE_01
        end
    end

    // speed clamp, only in torque mode; the speed loop holds speed_ref_o while asserted
    wire signed [16:0] spd_ext = {speed_act_i[15], speed_act_i};
    wire signed [16:0] fwd_sc_s = $signed({4'h0, fwd_speed_clamp_torque_mode});
    wire signed [16:0] rev_sc_s = -$signed({4'h0, rev_speed_clamp_torque_mode});
    wire in_trq = (mode == tsms_pkg::TSMS_TRQ); // RULE_04
    wire sc_hi = in_trq && (spd_ext >= fwd_sc_s);
    wire sc_lo = in_trq && (spd_ext <= rev_sc_s);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            speed_clamp_o <= 1'b0;
            speed_ref_o <= 16'sh0000;
        end else begin
            speed_clamp_o <= sc_hi || sc_lo; // RULE_02
            speed_ref_o <= sc_hi ? fwd_sc_s[15:0] : sc_lo ? rev_sc_s[15:0] : 16'sh0000;
        end
    end

    // torque arrival with hysteresis
    logic torque_arrival_flag;
    tsms_hyst u_hyst (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .torque_i(torque_act_i),
        .thr_i(arrival_threshold),
        .hys_i(arrival_hysteresis),
        .arrived_o(torque_arrival_flag)
    );

    // output terminals
    tsms_do_map #(.N_DO(N_DO)) u_do (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .limited_i(torque_limited),
        .arrived_i(torque_arrival_flag),
        .func_i(do_func),
        .lvl_i(do_lvl),
        .do_o(do_o)
    );

    // rising edges and mode changes become sticky events; a new event beats a same-cycle clear
    logic arr_q;
    logic tlim_q;
    logic sc_q;
    logic [2:0] mode_q;
    logic [3:0] events;
    assign events[`TSMS_EV_ARR] = torque_arrival_flag && !arr_q;
    assign events[`TSMS_EV_TLIM] = torque_limited && !tlim_q;
    assign events[`TSMS_EV_SCLP] = speed_clamp_o && !sc_q;
    assign events[`TSMS_EV_MODE] = (mode != mode_q);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            arr_q <= 1'b0;
            tlim_q <= 1'b0;
            sc_q <= 1'b0;
            mode_q <= tsms_pkg::TSMS_POS;
            irq_stat <= 4'h0;
        end else begin
            arr_q <= torque_arrival_flag;
            tlim_q <= torque_limited;
            sc_q <= speed_clamp_o;
            mode_q <= mode;
            irq_stat <= (irq_stat & ~(wr_istat ? wdata_i[3:0] : 4'h0)) | events;
        end
    end
    assign irq_o = |(irq_stat & irq_mask);

    // read mux; unmapped addresses read zero
    wire [31:0] rd_mux =
        (addr_i == `TSMS_A_MODE) ? {29'h0, mode_setting} :
        (addr_i == `TSMS_A_FWD_TLIM) ? {20'h0, fwd_tlim} :
        (addr_i == `TSMS_A_REV_TLIM) ? {20'h0, rev_tlim} :
        (addr_i == `TSMS_A_FWD_SCLP) ? {19'h0, fwd_speed_clamp_torque_mode} :
        (addr_i == `TSMS_A_REV_SCLP) ? {19'h0, rev_speed_clamp_torque_mode} :
        (addr_i == `TSMS_A_ARR_THR) ? {23'h0, arrival_threshold} :
        (addr_i == `TSMS_A_ARR_HYS) ? {27'h0, arrival_hysteresis} :
        (addr_i == `TSMS_A_STATUS) ? {20'h0, mixed_mode_selector, speed_clamp_o,
                                      torque_limited, torque_arrival_flag, 1'b0, mode,
                                      1'b0, mode_setting} :
        (addr_i == `TSMS_A_IRQ_STAT) ? {28'h0, irq_stat} :
        (addr_i == `TSMS_A_IRQ_MASK) ? {28'h0, irq_mask} :
        (addr_i == `TSMS_A_DO_FUNC) ? 32'(do_func) :
        (addr_i == `TSMS_A_DO_LVL) ? 32'(do_lvl) :
        (addr_i == `TSMS_A_DI_FUNC) ? 32'(di_func) :
        (addr_i == `TSMS_A_DI_LVL) ? 32'(di_lvl) :
        32'h0;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 32'h0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 32'h0;
        end
    end
endmodule
`default_nettype wire
